// ---- src/cmd_decoder.sv ----
// Memory map decoder and core register set
// Operation
// - Program memory is read only
// - 16-bit PC plus bank bit: 128K
// - Fetch starts at address zero
// - Fixed vectors, external interrupt 0 at 0003H
// - Vectors spaced eight bytes apart
// - 8-bit data addresses, 16-bit via pointer
// - 256 bytes internal data RAM
// - Upper half: direct SFR, indirect RAM
// - Lowest 32 bytes: four register banks
// - Bank chosen by status word field
// - 16 bit-addressable bytes, bits 00H-7FH
// - Lower 128 direct and indirect
// - Upper 128 only indirect
// - 4K nonvolatile, 8K SRAM through SFRs (code: separate NVM and XS ports, no SFR)
// - Stack pointer 81H, resets 07H
// - Data pointer 82H/83H, reset zero
// - Alternate low pointer 84H, reset zero
`timescale 1ns/1ps
`include "cmd_consts.svh"
module cmd_decoder
  import cmd_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        FETCH_NEXT,
  input  wire logic        JUMP_EN,
  input  wire logic [15:0] JUMP_ADDR,
  input  wire logic        BANK_SEL,
  input  wire logic        IRQ_TAKE,
  input  wire logic [2:0]  IRQ_NUM,
  input  wire logic        DATA_EN,
  input  wire logic        DATA_WE,
  input  wire logic        DATA_INDIRECT,
  input  wire logic [7:0]  DATA_ADDR,
  input  wire logic [7:0]  DATA_WDATA,
  input  wire logic        REG_EN,
  input  wire logic [2:0]  REG_NUM,
  input  wire logic        BIT_EN,
  input  wire logic        BIT_WE,
  input  wire logic [6:0]  BIT_ADDR,
  input  wire logic        BIT_WDATA,
  input  wire logic        NVM_EN,
  input  wire logic        NVM_WE,
  input  wire logic [11:0] NVM_ADDR,
  input  wire logic        XS_EN,
  input  wire logic        XS_WE,
  input  wire logic [12:0] XS_ADDR,
  input  wire logic [7:0]  XS_WDATA,
  output logic      [16:0] PROG_ADDR,
  output logic      [7:0]  DATA_RDATA,
  output logic             BIT_RDATA,
  output logic      [15:0] DATA_POINTER_PAIR,
  output logic      [7:0]  NVM_RDATA,
  output logic      [7:0]  XS_RDATA
);
  // Registers
  logic [15:0] pc;
  logic        bank;
  logic [7:0]  stack_pointer, data_pointer_low, data_pointer_high, data_pointer_low_alt;
  logic [7:0]  arith_primary, multiply_divide_aux, program_status_word;
  logic [7:0]  lower_ram [0:127];
  logic [7:0]  sfr_q, lower_q;
  logic        bit_q;
  logic        lower_sel_q, upper_sel_q;
  cmd_space_t  space;

  function automatic logic [15:0] vector_of(input logic [2:0] n);
    vector_of = `CMD_VECTOR_BASE + (16'(n) << `CMD_VECTOR_STEP);
  endfunction : vector_of

  // only an address leaves toward program memory; no write path exists
  wire [15:0] next_pc = IRQ_TAKE ? vector_of(IRQ_NUM) :
                        JUMP_EN  ? JUMP_ADDR :
                        FETCH_NEXT ? pc + 16'h0001 : pc;
  // Interrupt routines stay in the low bank, so the bank register clears on entry
  wire        next_bank = IRQ_TAKE ? 1'b0 : JUMP_EN ? BANK_SEL : bank;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pc   <= `CMD_RESET_VECTOR;
      bank <= 1'b0;
    end else begin
      pc   <= next_pc;
      bank <= next_bank;
    end
  end

  // Vectors live in the low bank, so fetch after entry stays there too
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PROG_ADDR <= {1'b0, `CMD_RESET_VECTOR};
    end else begin
      PROG_ADDR <= {next_bank, next_pc};
    end
  end

  // Space decode: indirect upper goes to RAM, direct upper to SFRs
  assign space = !DATA_ADDR[7]  ? CMD_SPACE_LOWER :
                 DATA_INDIRECT ? CMD_SPACE_UPPER : CMD_SPACE_SFR;

  // Register bank number picks a group of eight in the lowest 32 bytes
  wire [1:0] rbank = program_status_word[`CMD_PSW_RS_LSB +: 2];
  wire [6:0] reg_addr = {2'b00, rbank, REG_NUM};
  wire [6:0] bit_byte = 7'(`CMD_BITAREA_BASE) + {3'b000, BIT_ADDR[6:3]};
  wire [6:0] lower_addr = REG_EN ? reg_addr : BIT_EN ? bit_byte : DATA_ADDR[6:0];
  wire       lower_we = DATA_EN && DATA_WE && space == CMD_SPACE_LOWER;
  wire       upper_we = DATA_EN && DATA_WE && space == CMD_SPACE_UPPER;
  wire       sfr_we   = DATA_EN && DATA_WE && space == CMD_SPACE_SFR;

  wire [7:0] bit_old  = lower_ram[bit_byte];
  wire [7:0] bit_new  = (bit_old & ~(8'h01 << BIT_ADDR[2:0])) |
                        ({7'h00, BIT_WDATA} << BIT_ADDR[2:0]);

  always_ff @(posedge MCLK) begin
    if (BIT_EN && BIT_WE) begin
      lower_ram[bit_byte] <= bit_new;
    end else if (lower_we || (REG_EN && DATA_WE)) begin
      lower_ram[lower_addr] <= DATA_WDATA;
    end
    lower_q <= lower_ram[lower_addr];
    bit_q   <= bit_old[BIT_ADDR[2:0]];
  end

  logic [7:0] upper_q;
  // Upper half is a separate array, never reached by direct access
  cmd_ram #(.AW(7)) u_upper (
    .clk   (MCLK),
    .we    (upper_we),
    .addr  (DATA_ADDR[6:0]),
    .wdata (DATA_WDATA),
    .rdata (upper_q)
  );

  logic [7:0] nvm_q, xs_q;
  // Nonvolatile area modelled as array; retention is outside this block
  cmd_ram #(.AW(`CMD_NVM_AW)) u_nvm (
    .clk   (MCLK),
    .we    (NVM_EN && NVM_WE),
    .addr  (NVM_ADDR),
    .wdata (XS_WDATA),
    .rdata (nvm_q)
  );
  cmd_ram #(.AW(`CMD_EXTENDED_DATA_SRAM_AW)) u_xs (
    .clk   (MCLK),
    .we    (XS_EN && XS_WE),
    .addr  (XS_ADDR),
    .wdata (XS_WDATA),
    .rdata (xs_q)
  );

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      stack_pointer        <= `CMD_SP_RESET;
      data_pointer_low     <= `CMD_ZERO_RESET;
      data_pointer_high    <= `CMD_ZERO_RESET;
      data_pointer_low_alt <= `CMD_ZERO_RESET;
      arith_primary        <= `CMD_ZERO_RESET;
      multiply_divide_aux  <= `CMD_ZERO_RESET;
      program_status_word  <= `CMD_ZERO_RESET;
    end else if (sfr_we) begin
      unique case (DATA_ADDR)
        `CMD_SFR_SP:      stack_pointer        <= DATA_WDATA;
        `CMD_SFR_DPL:     data_pointer_low     <= DATA_WDATA;
        `CMD_SFR_DPH:     data_pointer_high    <= DATA_WDATA;
        `CMD_SFR_DPL_ALT: data_pointer_low_alt <= DATA_WDATA;
        `CMD_SFR_ACC:     arith_primary        <= DATA_WDATA;
        `CMD_SFR_AUX:     multiply_divide_aux  <= DATA_WDATA;
        `CMD_SFR_PSW:     program_status_word  <= DATA_WDATA;
        default: ;
      endcase
    end
  end

  // Unmapped SFR addresses read as zero
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sfr_q <= 8'h00;
    end else begin
      unique case (DATA_ADDR)
        `CMD_SFR_SP:      sfr_q <= stack_pointer;
        `CMD_SFR_DPL:     sfr_q <= data_pointer_low;
        `CMD_SFR_DPH:     sfr_q <= data_pointer_high;
        `CMD_SFR_DPL_ALT: sfr_q <= data_pointer_low_alt;
        `CMD_SFR_ACC:     sfr_q <= arith_primary;
        `CMD_SFR_AUX:     sfr_q <= multiply_divide_aux;
        `CMD_SFR_PSW:     sfr_q <= program_status_word;
        default:          sfr_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      lower_sel_q <= 1'b0;
      upper_sel_q <= 1'b0;
    end else begin
      lower_sel_q <= REG_EN || space == CMD_SPACE_LOWER;
      upper_sel_q <= !REG_EN && space == CMD_SPACE_UPPER;
    end
  end

  // Read data is two cycles after the request, muxed from registered sources
  wire [7:0] next_rdata = lower_sel_q ? lower_q : upper_sel_q ? upper_q : sfr_q;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      DATA_RDATA        <= 8'h00;
      BIT_RDATA         <= 1'b0;
      DATA_POINTER_PAIR <= 16'h0000;
      NVM_RDATA         <= 8'h00;
      XS_RDATA          <= 8'h00;
    end else begin
      DATA_RDATA        <= next_rdata;
      BIT_RDATA         <= bit_q;
      DATA_POINTER_PAIR <= {data_pointer_high, data_pointer_low};
      NVM_RDATA         <= nvm_q;
      XS_RDATA          <= xs_q;
    end
  end

  a_reset_fetch: assert property (@(posedge MCLK)
    SRST |=> PROG_ADDR == 17'h00000) else $error("fetch not at zero after reset");
  a_vector_place: assert property (@(posedge MCLK) disable iff (SRST)
    IRQ_TAKE |=> PROG_ADDR == {1'b0, 16'h0003 + {10'h000, $past(IRQ_NUM), 3'b000}})
    else $error("vector address wrong");
  a_sp_reset: assert property (@(posedge MCLK)
    SRST |=> stack_pointer == 8'h07) else $error("stack pointer reset wrong");
  a_data_pointer_pair_reset: assert property (@(posedge MCLK)
    SRST |=> ##1 DATA_POINTER_PAIR == 16'h0000 && data_pointer_low_alt == 8'h00)
    else $error("data pointer reset wrong");
  a_upper_direct: assert property (@(posedge MCLK) disable iff (SRST)
    (DATA_EN && DATA_WE && DATA_ADDR[7] && !DATA_INDIRECT) |-> !upper_we)
    else $error("direct access reached upper RAM");
  a_upper_ind: assert property (@(posedge MCLK) disable iff (SRST)
    (DATA_EN && DATA_WE && DATA_ADDR[7] && DATA_INDIRECT) |-> upper_we && !sfr_we)
    else $error("indirect access missed upper RAM");
  a_data_pointer_pair_write: assert property (@(posedge MCLK) disable iff (SRST)
    (sfr_we && DATA_ADDR == 8'h83) |=> ##1 DATA_POINTER_PAIR[15:8] == $past(DATA_WDATA, 2))
    else $error("data pointer high not written");
  a_bank_reg: assert property (@(posedge MCLK) disable iff (SRST)
    REG_EN |-> lower_addr == {2'b00, program_status_word[4:3], REG_NUM})
    else $error("register bank address wrong");
  a_pc_step: assert property (@(posedge MCLK) disable iff (SRST)
    (FETCH_NEXT && !JUMP_EN && !IRQ_TAKE) |=> pc == $past(pc) + 16'h0001)
    else $error("program counter did not step");

  // The stack pointer and alternate pointer checks are built from named request sequences
  sequence s_sp_write;
    sfr_we && DATA_ADDR == 8'h81;
  endsequence

  sequence s_alt_write;
    sfr_we && DATA_ADDR == 8'h84;
  endsequence

  sequence s_sp_read;
    DATA_EN && !DATA_WE && !DATA_INDIRECT && !REG_EN && DATA_ADDR == 8'h81;
  endsequence

  a_irq_bank: assert property (@(posedge MCLK) disable iff (SRST)
    IRQ_TAKE |=> bank == 1'b0) else $error("interrupt left high bank");
  a_jump_load: assert property (@(posedge MCLK) disable iff (SRST)
    (JUMP_EN && !IRQ_TAKE) |=> PROG_ADDR == {$past(BANK_SEL), $past(JUMP_ADDR)})
    else $error("jump address wrong");
  a_pc_hold: assert property (@(posedge MCLK) disable iff (SRST)
    (!FETCH_NEXT && !JUMP_EN && !IRQ_TAKE) |=> PROG_ADDR == $past(PROG_ADDR))
    else $error("program address moved while idle");
  a_sp_write: assert property (@(posedge MCLK) disable iff (SRST)
    s_sp_write |=> stack_pointer == $past(DATA_WDATA))
    else $error("stack pointer not written");
  a_alt_write: assert property (@(posedge MCLK) disable iff (SRST)
    s_alt_write |=> data_pointer_low_alt == $past(DATA_WDATA))
    else $error("alternate pointer not written");
  a_sp_read: assert property (@(posedge MCLK) disable iff (SRST)
    s_sp_read |=> ##1 DATA_RDATA == $past(stack_pointer, 2))
    else $error("stack pointer read wrong");
  a_bit_area: assert property (@(posedge MCLK) disable iff (SRST)
    BIT_EN |-> bit_byte[6:4] == 3'b010)
    else $error("bit access outside bit area");
  a_reg_range: assert property (@(posedge MCLK) disable iff (SRST)
    REG_EN |-> reg_addr < 7'h20)
    else $error("register outside bank area");
  a_lower_both: assert property (@(posedge MCLK) disable iff (SRST)
    (DATA_EN && DATA_WE && !DATA_ADDR[7]) |-> lower_we && !upper_we && !sfr_we)
    else $error("lower write misrouted");
endmodule : cmd_decoder

// ---- shared/cmd_consts.svh ----
// Constants for the core memory map decoder
`ifndef CMD_CONSTS_SVH
`define CMD_CONSTS_SVH
`define CMD_SFR_SP        8'h81
`define CMD_SFR_DPL       8'h82
`define CMD_SFR_DPH       8'h83
`define CMD_SFR_DPL_ALT   8'h84
`define CMD_SFR_PSW       8'hD0
`define CMD_SFR_ACC       8'hE0
`define CMD_SFR_AUX       8'hF0
`define CMD_SP_RESET      8'h07
`define CMD_ZERO_RESET    8'h00
`define CMD_RESET_VECTOR  16'h0000
`define CMD_VECTOR_BASE   16'h0003
`define CMD_VECTOR_STEP   3
`define CMD_UPPER_BASE    8'h80
`define CMD_BITAREA_BASE  8'h20
`define CMD_PSW_RS_LSB    3
`define CMD_NVM_AW        12
`define CMD_EXTENDED_DATA_SRAM_AW      13
`endif

// ---- shared/cmd_pkg.sv ----
// Types for the core memory map decoder
package cmd_pkg;
  typedef enum logic [1:0] {
    CMD_SPACE_LOWER,
    CMD_SPACE_UPPER,
    CMD_SPACE_SFR
  } cmd_space_t;
endpackage : cmd_pkg

// ---- src/cmd_ram.sv ----
// Single-port byte RAM with synchronous read
`timescale 1ns/1ps
module cmd_ram #(
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : cmd_ram

// ---- test/cmd_core_model.sv ----
// Core-side model: issues fetch, data, bit and external-area requests
`timescale 1ns/1ps
module cmd_core_model (
  input  wire logic        MCLK,
  output logic             FETCH_NEXT, JUMP_EN, BANK_SEL, IRQ_TAKE, DATA_EN, DATA_WE,
  output logic             DATA_INDIRECT, REG_EN, BIT_EN, BIT_WE, BIT_WDATA,
  output logic             NVM_EN, NVM_WE, XS_EN, XS_WE,
  output logic      [15:0] JUMP_ADDR,
  output logic      [2:0]  IRQ_NUM, REG_NUM,
  output logic      [7:0]  DATA_ADDR, DATA_WDATA, XS_WDATA,
  output logic      [6:0]  BIT_ADDR,
  output logic      [11:0] NVM_ADDR,
  output logic      [12:0] XS_ADDR
);
  initial begin
    {FETCH_NEXT, JUMP_EN, BANK_SEL, IRQ_TAKE, DATA_EN, DATA_WE, DATA_INDIRECT} = '0;
    {REG_EN, BIT_EN, BIT_WE, BIT_WDATA, NVM_EN, NVM_WE, XS_EN, XS_WE} = '0;
    {JUMP_ADDR, IRQ_NUM, REG_NUM, DATA_ADDR, DATA_WDATA, XS_WDATA} = '0;
    {BIT_ADDR, NVM_ADDR, XS_ADDR} = '0;
  end
  // Released data lines flip so a stale value never looks held
  task automatic go;
    @(negedge MCLK);
    {DATA_EN, DATA_WE, REG_EN, BIT_EN, BIT_WE, NVM_EN, NVM_WE, XS_EN, XS_WE} = '0;
    DATA_WDATA = ~DATA_WDATA;
    XS_WDATA = ~XS_WDATA;
    repeat (2) @(posedge MCLK);
    @(negedge MCLK);
  endtask : go
  task automatic data(input logic we, ind, input logic [7:0] a, d);
    @(negedge MCLK);
    {DATA_EN, DATA_WE, DATA_INDIRECT, DATA_ADDR, DATA_WDATA} = {1'b1, we, ind, a, d};
    go();
  endtask : data
  task automatic regw(input logic [2:0] n, input logic [7:0] d);
    @(negedge MCLK);
    {REG_EN, DATA_WE, REG_NUM, DATA_WDATA} = {2'b11, n, d};
    go();
  endtask : regw
  task automatic bitw(input logic we, input logic [6:0] a, input logic v);
    @(negedge MCLK);
    {BIT_EN, BIT_WE, BIT_ADDR, BIT_WDATA} = {1'b1, we, a, v};
    go();
  endtask : bitw
  task automatic ext(input logic xs, we, input logic [12:0] a, input logic [7:0] d);
    @(negedge MCLK);
    {NVM_EN, XS_EN, NVM_WE, XS_WE} = {~xs, xs, we & ~xs, we & xs};
    {XS_ADDR, NVM_ADDR, XS_WDATA} = {a, a[11:0], d};
    go();
  endtask : ext
  // kind bits: take interrupt, jump, fetch; held for exactly one edge
  task automatic pc(input logic [2:0] kind, input logic [15:0] a, input logic [2:0] n,
                    input logic b);
    @(negedge MCLK);
    {IRQ_TAKE, JUMP_EN, FETCH_NEXT, JUMP_ADDR, IRQ_NUM, BANK_SEL} = {kind, a, n, b};
    @(negedge MCLK);
    {IRQ_TAKE, JUMP_EN, FETCH_NEXT} = '0;
  endtask : pc
endmodule : cmd_core_model

// ---- test/tb_top.sv ----
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module tb_top;
  logic MCLK, SRST, FETCH_NEXT, JUMP_EN, BANK_SEL, IRQ_TAKE, DATA_EN, DATA_WE, DATA_INDIRECT;
  logic REG_EN, BIT_EN, BIT_WE, BIT_WDATA, NVM_EN, NVM_WE, XS_EN, XS_WE, BIT_RDATA;
  logic [15:0] JUMP_ADDR, DATA_POINTER_PAIR;
  logic [2:0]  IRQ_NUM, REG_NUM;
  logic [7:0]  DATA_ADDR, DATA_WDATA, XS_WDATA, DATA_RDATA, NVM_RDATA, XS_RDATA, a, d;
  logic [6:0]  BIT_ADDR, b;
  logic [11:0] NVM_ADDR;
  logic [12:0] XS_ADDR, ea;
  logic [16:0] PROG_ADDR;
  logic        ind, we, up, bv;
  int          err_count, checks_done, seed, i;
  logic [7:0]  ram [256];
  logic [7:0]  sfr [256];
  logic [7:0]  sfr_a [6] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'hE0, 8'hF0};
  cmd_decoder dut (.*);
  cmd_core_model core (.*);
  task automatic check(input logic [16:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Model registers return to their reset values, then each except the status word (D0H) is read back
  task automatic reset_and_check;
    SRST = 1'b1;
    repeat (5) @(negedge MCLK);
    SRST = 1'b0;
    foreach (sfr[k]) sfr[k] = 8'h00;
    sfr[8'h81] = 8'h07;
    check(PROG_ADDR, 17'h0);
    foreach (sfr_a[k]) begin
      core.data(1'b0, 1'b0, sfr_a[k], 8'h00);
      check(DATA_RDATA, sfr[sfr_a[k]]);
    end
  endtask : reset_and_check
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  initial begin
    #2000000;
    err_count++;
    test_done();
  end
  initial begin
    seed = 44;
    err_count = 0;
    checks_done = 0;
    reset_and_check();
    for (i = 0; i < 256; i++) begin
      ram[i] = 8'($random(seed));
      core.data(1'b1, 1'b1, i[7:0], ram[i]);
    end
    foreach (sfr_a[k]) begin
      sfr[sfr_a[k]] = 8'($random(seed));
      core.data(1'b1, 1'b0, sfr_a[k], sfr[sfr_a[k]]);
    end
    // Mixed traffic; direct upper half goes to registers, unmapped ones read 0
    repeat (400) begin
      {a, d, ind, we} = 18'($random(seed));
      if (!ind && a[7] && (i % 3 != 0)) a = sfr_a[i % 6];
      i++;
      core.data(we, ind, a, d);
      up = ind | ~a[7];
      if (we && up) ram[a] = d;
      else if (we && (a inside {8'h81, 8'h82, 8'h83, 8'h84, 8'hE0, 8'hF0})) sfr[a] = d;
      if (!we && a != 8'hD0) check(DATA_RDATA, up ? ram[a] : sfr[a]);
    end
    check(DATA_POINTER_PAIR, {sfr[8'h83], sfr[8'h82]});
    for (i = 0; i < 32; i++) begin
      if (i % 8 == 0) core.data(1'b1, 1'b0, 8'hD0, {3'b000, i[4:3], 3'b000});
      ram[i] = 8'($random(seed));
      core.regw(i[2:0], ram[i]);
    end
    for (i = 0; i < 32; i++) begin
      core.data(1'b0, i[0], i[7:0], 8'h00);
      check(DATA_RDATA, ram[i]);
    end
    repeat (24) begin
      {b, bv} = 8'($random(seed));
      core.bitw(1'b1, b, bv);
      ram[{4'h2, b[6:3]}][b[2:0]] = bv;
      core.bitw(1'b0, b, 1'b0);
      check(BIT_RDATA, bv);
      core.data(1'b0, 1'b0, {4'h2, b[6:3]}, 8'h00);
      check(DATA_RDATA, ram[{4'h2, b[6:3]}]);
    end
    for (i = 0; i < 16; i++) begin
      ea = (i < 2) ? 13'h1FFF : 13'($random(seed));
      d = 8'($random(seed));
      core.ext(i[0], 1'b1, ea, d);
      core.ext(i[0], 1'b0, ea, 8'h00);
      check(i[0] ? XS_RDATA : NVM_RDATA, d);
    end
    core.pc(3'b001, 16'h0000, 3'h0, 1'b0);
    check(PROG_ADDR, 17'h00001);
    core.pc(3'b010, 16'hFFFE, 3'h0, 1'b1);
    check(PROG_ADDR, 17'h1FFFE);
    core.pc(3'b001, 16'h0000, 3'h0, 1'b0);
    check(PROG_ADDR, 17'h1FFFF);
    for (i = 0; i < 8; i++) begin
      core.pc(i[0] ? 3'b111 : 3'b100, 16'h1234, i[2:0], 1'b1);
      check(PROG_ADDR, 17'h00003 + 17'(8 * i));
    end
    core.pc(3'b001, 16'h0000, 3'h0, 1'b0);
    check(PROG_ADDR, 17'h0003C);
    reset_and_check();
    test_done();
  end
endmodule : tb_top
